// >>> hw/imseq_sequencer.sv
/*
  Integrate/measure sequencer of a dual-integrator current-input
  converter: eight-state machine, measure-busy timing, data-ready flag
  and offset-binary serial result word.
  Assumes the conversion toggle and serial data clock come from pins
  driven by a host, and that the analog front end supplies a signed
  result code per side.
*/
`timescale 1ns/1ps
module imseq_sequencer #(
  parameter bit HIGH_SPEED = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_conversion_toggle,
  input wire logic i_serial_data_clock,
  input wire logic i_clock_divide_by_four,
  input wire logic i_format_full,
  input wire logic [19:0] i_code_a,
  input wire logic [19:0] i_code_b,
  output logic o_data_ready_n,
  output logic o_serial_out,
  output logic [2:0] o_state,
  output logic o_continuous,
  output logic o_measure_busy,
  output logic o_inputs_grounded,
  output logic o_integrate_a,
  output logic o_integrate_b,
  output logic o_measure_side_b,
  output logic [1:0] o_phase
);

  // ****************************************
  // Variant and state record
  // ****************************************
  localparam logic [11:0] MEASURE_CYCLE_TIME = HIGH_SPEED ?
    imseq_pkg::MEASURE_CYCLE_TIME_HS : imseq_pkg::MEASURE_CYCLE_TIME_LP;

  typedef struct packed {
    imseq_pkg::imseq_state_e state;
    logic [1:0] init_cnt;
    logic up;
    logic conversion_toggle_s1;
    logic conversion_toggle_s2;
    logic conversion_toggle_seen;
    logic dck_s1;
    logic dck_s2;
    logic dck_s3;
    logic div_s1;
    logic div_s2;
    logic fmt_s1;
    logic fmt_s2;
    logic pend_a;
    logic pend_b;
    logic measuring;
    logic prep;
    logic last_b;
    logic [1:0] rdq;
    logic rd_b;
    logic ready_n;
    logic dck_hi;
    logic [19:0] shift;
    logic sout;
  } imseq_seq_s;

  imseq_seq_s r;
  imseq_seq_s next_r;

  imseq_timer_if meas ();
  imseq_timer_if rdy ();

  imseq_phase_timer u_meas_timer (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .tmr(meas.timer)
  );

  imseq_phase_timer u_ready_timer (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .tmr(rdy.timer)
  );

  // Offset binary with clipping to zero at the low end of the code range; no signed code reaches the full-scale clip
  function automatic logic [19:0] to_offset(input logic [19:0] c);
    logic [21:0] s;
    s = {{2{c[19]}}, c} + {2'h0, imseq_pkg::OFFSET_CODE};
    if (s[21]) begin
      to_offset = '0;
    end else if (s[20]) begin
      to_offset = imseq_pkg::FULL_SCALE_CODE;
    end else begin
      to_offset = s[19:0];
    end
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  logic toggle;
  logic mbsy;
  logic dck_rise;
  logic dck_fall;
  logic [19:0] word;

  always_comb begin
    next_r = r;
    next_r.conversion_toggle_s1 = i_conversion_toggle;
    next_r.conversion_toggle_s2 = r.conversion_toggle_s1;
    next_r.dck_s1 = i_serial_data_clock;
    next_r.dck_s2 = r.dck_s1;
    next_r.dck_s3 = r.dck_s2;
    next_r.div_s1 = i_clock_divide_by_four;
    next_r.div_s2 = r.div_s1;
    next_r.fmt_s1 = i_format_full;
    next_r.fmt_s2 = r.fmt_s1;
    toggle = r.conversion_toggle_s2 != r.conversion_toggle_seen;
    mbsy = meas.busy && r.measuring;
    dck_rise = r.dck_s2 && !r.dck_s3;
    dck_fall = !r.dck_s2 && r.dck_s3;
    meas.start = 1'b0;
    meas.length = MEASURE_CYCLE_TIME;
    meas.div4 = r.div_s2;
    rdy.start = 1'b0;
    rdy.length = imseq_pkg::CONTINUOUS_READY_DELAY;
    rdy.div4 = r.div_s2;
    word = to_offset(r.rd_b ? i_code_b : i_code_a);
    if (!r.fmt_s2) begin
      word = {word[19:4], imseq_pkg::DROPPED_ZERO};
    end
    if (meas.done) begin
      next_r.measuring = 1'b0;
      next_r.prep = 1'b0;
    end

    if (!r.up) begin
      if (r.init_cnt == imseq_pkg::INIT_SETTLE) begin
        next_r.up = 1'b1;
        next_r.last_b = r.conversion_toggle_s2;
        next_r.conversion_toggle_seen = r.conversion_toggle_s2;
        next_r.state = r.conversion_toggle_s2 ? imseq_pkg::ST_FINISH_A
                                 : imseq_pkg::ST_FINISH_B;
      end else begin
        next_r.init_cnt = r.init_cnt + 2'h1;
      end
    end else begin
      case (r.state)
        imseq_pkg::ST_FINISH_A, imseq_pkg::ST_FINISH_B: begin
          next_r.conversion_toggle_seen = r.conversion_toggle_s2;
          if (!mbsy && !meas.done) begin
            if (r.pend_a || r.pend_b) begin
              // Finish the side left over from the drop
              meas.start = 1'b1;
              next_r.measuring = 1'b1;
              next_r.last_b = r.pend_b;
              next_r.pend_a = 1'b0;
              next_r.pend_b = 1'b0;
            end else begin
              meas.start = 1'b1;
              meas.length = imseq_pkg::PREPARE_CYC;
              next_r.prep = 1'b1;
              next_r.state = (r.state == imseq_pkg::ST_FINISH_A) ?
                imseq_pkg::ST_PREP_A : imseq_pkg::ST_PREP_B;
            end
          end
        end
        imseq_pkg::ST_PREP_A: begin
          if (meas.done) begin
            next_r.state = imseq_pkg::ST_INT_A;
          end
        end
        imseq_pkg::ST_PREP_B: begin
          if (meas.done) begin
            next_r.state = imseq_pkg::ST_INT_B;
          end
        end
        default: begin
          if (toggle) begin
            next_r.conversion_toggle_seen = r.conversion_toggle_s2;
            if (mbsy) begin
              // Integration ended before the other side was measured
              next_r.rdq = r.rdq + 2'h1;
              if (r.state == imseq_pkg::ST_INT_B_MEAS_A) begin
                next_r.pend_b = 1'b1;
                next_r.state = imseq_pkg::ST_FINISH_A;
              end else begin
                next_r.pend_a = 1'b1;
                next_r.state = imseq_pkg::ST_FINISH_B;
              end
            end else begin
              // Side just integrated is measured next
              meas.start = 1'b1;
              next_r.measuring = 1'b1;
              next_r.last_b = !r.last_b;
              rdy.start = 1'b1;
              next_r.rdq = 2'h1;
              next_r.rd_b = !r.last_b;
              next_r.state = r.last_b ? imseq_pkg::ST_INT_B_MEAS_A
                : imseq_pkg::ST_INT_A_MEAS_B;
            end
          end
        end
      endcase
    end

    // ****************************************
    // Data-ready flag and serial word
    // ****************************************
    if (dck_fall) begin
      next_r.sout = r.shift[19];
      next_r.shift = {r.shift[18:0], 1'b0};
    end
    if (!r.ready_n && dck_rise) begin
      next_r.dck_hi = 1'b1;
    end
    if (!r.ready_n && dck_fall && r.dck_hi) begin
      next_r.ready_n = 1'b1;
      next_r.dck_hi = 1'b0;
    end
    if (rdy.done && r.rdq != 2'h0) begin
      // New data beats a release in the same cycle
      next_r.ready_n = 1'b0;
      next_r.dck_hi = 1'b0;
      next_r.shift = {word[18:0], 1'b0};
      next_r.sout = word[19];
      next_r.rdq = next_r.rdq - 2'h1;
      next_r.rd_b = !r.rd_b;
      if (r.rdq != 2'h1) begin
        rdy.start = 1'b1;
        rdy.length = imseq_pkg::READY_GAP_CYC;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '{state: imseq_pkg::ST_FINISH_B, ready_n: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic ncont;
  assign ncont = r.state == imseq_pkg::ST_FINISH_A ||
                 r.state == imseq_pkg::ST_PREP_A ||
                 r.state == imseq_pkg::ST_PREP_B ||
                 r.state == imseq_pkg::ST_FINISH_B;

  always_comb begin
    o_phase = imseq_pkg::PH_IDLE;
    if (mbsy) begin
      if (meas.elapsed < imseq_pkg::CONVERSION_CYC) begin
        o_phase = imseq_pkg::PH_CONVERT;
      end else if (meas.elapsed < imseq_pkg::CONVERSION_CYC +
                   imseq_pkg::CONVERSION_TOGGLE_RESET_CYC) begin
        o_phase = imseq_pkg::PH_CONVERSION_TOGGLE_RESET;
      end else if (meas.elapsed < imseq_pkg::CONVERSION_CYC +
                   imseq_pkg::CONVERSION_TOGGLE_RESET_CYC + imseq_pkg::INT_RESET_CYC) begin
        o_phase = imseq_pkg::PH_INT_RESET;
      end
    end
  end

  assign o_data_ready_n = r.ready_n;
  assign o_serial_out = r.sout;
  assign o_state = r.state;
  assign o_continuous = r.up && !ncont;
  assign o_measure_busy = mbsy;
  assign o_inputs_grounded = !r.up || ncont;
  assign o_integrate_a = r.up && (r.state == imseq_pkg::ST_INT_A ||
                         r.state == imseq_pkg::ST_INT_A_MEAS_B);
  assign o_integrate_b = r.up && (r.state == imseq_pkg::ST_INT_B ||
                         r.state == imseq_pkg::ST_INT_B_MEAS_A);
  assign o_measure_side_b = r.last_b;

endmodule

// >>> shared/imseq_pkg.sv
/*
  Shared constants and types of the integrate/measure sequencer.
  Assumes one system clock; every count below is in system-clock periods
  with the divide-by-four option cleared.
*/
package imseq_pkg;

  // ****************************************
  // Sequencing counts
  // ****************************************
  localparam int CNT_W = 12;
  localparam logic [11:0] MEASURE_CYCLE_TIME_LP = 12'h0610;
  localparam logic [11:0] MEASURE_CYCLE_TIME_HS = 12'h064C;
  localparam logic [11:0] CONTINUOUS_READY_DELAY = 12'h0566;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // ****************************************
  // Phase times at the nominal low-power rate
  // ****************************************
  localparam longint VARIANT_RATE_KHZ = 5000;
  localparam longint NS_PER_KHZ_CYCLE = 1000000;
  localparam longint CONVERSION_PHASE_TIME_NS = 135600;
  localparam longint CONVERTER_RESET_TIME_NS = 3200;
  localparam longint INTEGRATOR_RESET_TIME_NS = 36000;
  localparam longint PAUSED_INTEGRATOR_RESET_TIME_NS = 30400;
  localparam longint RELEASE_PHASE_TIME_NS = 400;
  localparam longint FIRST_PAUSED_READY_DELAY_NS = 276500;
  localparam longint SECOND_PAUSED_READY_DELAY_NS = 304800;

  localparam logic [11:0] CONVERSION_CYC = 12'(
    CONVERSION_PHASE_TIME_NS * VARIANT_RATE_KHZ / NS_PER_KHZ_CYCLE);
  localparam logic [11:0] CONVERSION_TOGGLE_RESET_CYC = 12'(
    CONVERTER_RESET_TIME_NS * VARIANT_RATE_KHZ / NS_PER_KHZ_CYCLE);
  localparam logic [11:0] INT_RESET_CYC = 12'(
    INTEGRATOR_RESET_TIME_NS * VARIANT_RATE_KHZ / NS_PER_KHZ_CYCLE);
  localparam logic [11:0] PAUSED_RESET_CYC = 12'(
    PAUSED_INTEGRATOR_RESET_TIME_NS * VARIANT_RATE_KHZ / NS_PER_KHZ_CYCLE);
  // Least time, so round up
  localparam logic [11:0] RELEASE_CYC = 12'(
    (RELEASE_PHASE_TIME_NS * VARIANT_RATE_KHZ + NS_PER_KHZ_CYCLE - 1)
    / NS_PER_KHZ_CYCLE);
  localparam logic [11:0] FIRST_READY_CYC = 12'(
    FIRST_PAUSED_READY_DELAY_NS * VARIANT_RATE_KHZ / NS_PER_KHZ_CYCLE);
  localparam logic [11:0] SECOND_READY_CYC = 12'(
    SECOND_PAUSED_READY_DELAY_NS * VARIANT_RATE_KHZ / NS_PER_KHZ_CYCLE);
  localparam logic [11:0] READY_GAP_CYC = SECOND_READY_CYC - FIRST_READY_CYC;
  localparam logic [11:0] PREPARE_CYC = PAUSED_RESET_CYC + RELEASE_CYC;

  // ****************************************
  // Output word format
  // ****************************************
  localparam int WORD_W = 20;
  localparam int DROP_BITS = 4;
  localparam logic [19:0] OFFSET_CODE = 20'h0_1000;
  localparam logic [19:0] FULL_SCALE_CODE = 20'hF_FFFF;
  localparam logic [3:0] DROPPED_ZERO = 4'h0;
  localparam logic [1:0] INIT_SETTLE = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_FINISH_A,    // Ncont, complete measure of A then B
    ST_PREP_A,      // Ncont, prepare side A
    ST_INT_A,       // Cont, integrate A only
    ST_INT_B_MEAS_A,
    ST_INT_A_MEAS_B,
    ST_INT_B,       // Cont, integrate B only
    ST_PREP_B,      // Ncont, prepare side B
    ST_FINISH_B     // Ncont, complete measure of B then A
  } imseq_state_e;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_CONVERT,
    PH_CONVERSION_TOGGLE_RESET,
    PH_INT_RESET
  } imseq_phase_e;

endpackage

// >>> shared/imseq_timer_if.sv
/*
  Carrier between the sequencer and its phase timers.
  Assumes both ends sit on the same system clock.
*/
`timescale 1ns/1ps
interface imseq_timer_if;
  logic start;
  logic [11:0] length;
  logic div4;
  logic busy;
  logic done;
  logic [11:0] elapsed;

  modport timer (
    input start,
    input length,
    input div4,
    output busy,
    output done,
    output elapsed
  );
  modport user (
    output start,
    output length,
    output div4,
    input busy,
    input done,
    input elapsed
  );
endinterface

// >>> hw/imseq_phase_timer.sv
/*
  Down-counting phase timer: runs a length of system-clock periods,
  stretched by four when the divider option is set.
  Assumes start is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
module imseq_phase_timer (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  imseq_timer_if.timer tmr
);

  typedef struct packed {
    logic [11:0] remain;
    logic [11:0] elapsed;
    logic [1:0] pre;
    logic busy;
    logic done;
  } imseq_tmr_s;

  imseq_tmr_s r;
  imseq_tmr_s next_r;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (tmr.start) begin
      // Zero length would wrap and run 4096 periods; treat it as one period
      next_r.remain = (tmr.length == '0) ? 12'h001 : tmr.length;
      next_r.elapsed = '0;
      next_r.pre = '0;
      next_r.busy = 1'b1;
    end else if (r.busy) begin
      if (tmr.div4 && r.pre != imseq_pkg::PRESCALE_LAST) begin
        next_r.pre = r.pre + 2'h1;
      end else begin
        next_r.pre = '0;
        next_r.elapsed = r.elapsed + 12'h001;
        if (r.remain == 12'h001) begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end else begin
          next_r.remain = r.remain - 12'h001;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tmr.busy = r.busy;
  assign tmr.done = r.done;
  assign tmr.elapsed = r.elapsed;

endmodule

// >>> tb/imseq_sequencer_assertions.sv
/*
  Port checker of the integrate/measure sequencer.
  Assumes one system clock and the bind below the module.
*/
`timescale 1ns/1ps
module imseq_chk #(
  parameter bit HIGH_SPEED = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_conversion_toggle,
  input wire logic i_serial_data_clock,
  input wire logic i_clock_divide_by_four,
  input wire logic o_data_ready_n,
  input wire logic [2:0] o_state,
  input wire logic o_continuous,
  input wire logic o_measure_busy,
  input wire logic o_inputs_grounded,
  input wire logic o_integrate_a,
  input wire logic o_integrate_b,
  input wire logic o_measure_side_b
);
  // ****************************************
  // Busy length counter
  // ****************************************
  localparam int MEAS = HIGH_SPEED ? 1612 : 1552;
  int scl;
  logic [13:0] busy_cnt;
  assign scl = i_clock_divide_by_four ? 4 : 1;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_cnt <= 14'h0000;
    end else if (o_measure_busy) begin
      busy_cnt <= busy_cnt + 14'h0001;
    end else begin
      busy_cnt <= 14'h0000;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // ****************************************
  // Properties
  // ****************************************
  property p_reset_state;
    $rose(i_reset_n) |-> o_state == 3'd7 && o_inputs_grounded
      && o_data_ready_n;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state after reset wrong");
  property p_ground;
    o_inputs_grounded == !o_continuous
      && o_inputs_grounded == !(o_integrate_a || o_integrate_b)
      && !(o_integrate_a && o_integrate_b);
  endproperty
  a_ground: assert property (p_ground)
    else $error("grounding disagrees with mode");
  property p_cont_code;
    o_continuous == (o_state inside {[3'd2:3'd5]});
  endproperty
  a_cont_code: assert property (p_cont_code)
    else $error("mode flag disagrees with state");
  property p_side4;
    o_state == 3'd3 && o_measure_busy |-> o_integrate_b && !o_integrate_a
      && !o_measure_side_b;
  endproperty
  a_side4: assert property (p_side4)
    else $error("state 4 sides wrong");
  property p_side5;
    o_state == 3'd4 && o_measure_busy |-> o_integrate_a && !o_integrate_b
      && o_measure_side_b;
  endproperty
  a_side5: assert property (p_side5)
    else $error("state 5 sides wrong");
  // Tolerance covers the sync stages and the documented two periods
  property p_busy_len;
    $fell(o_measure_busy) |-> busy_cnt >= scl * MEAS - 8
      && busy_cnt <= scl * MEAS + 8;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("measure cycle length wrong");
  property p_ready_delay;
    $fell(o_data_ready_n) && o_continuous |-> busy_cnt >= scl * 1382 - 8
      && busy_cnt <= scl * 1382 + 8;
  endproperty
  a_ready_delay: assert property (p_ready_delay)
    else $error("ready delay wrong");
  property p_ready_hold;
    (!o_data_ready_n && !i_serial_data_clock) [*6] |=> !o_data_ready_n;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready released without serial clock");
  property p_release;
    !o_data_ready_n && i_serial_data_clock ##1 i_serial_data_clock [*2]
      ##1 !i_serial_data_clock |-> ##[1:6] o_data_ready_n;
  endproperty
  a_release: assert property (p_release)
    else $error("ready not released");
  property p_drop;
    $changed(i_conversion_toggle) && o_continuous && o_measure_busy
      ##1 o_measure_busy [*4] |-> ##[0:4] (o_state == 3'd0 || o_state == 3'd7);
  endproperty
  a_drop: assert property (p_drop)
    else $error("no drop to paused mode");
  c_drop: cover property (o_continuous ##1 !o_continuous);
  c_rejoin: cover property (o_state == 3'd6 ##1 o_state == 3'd5);
  c_div: cover property ($fell(o_data_ready_n) && i_clock_divide_by_four);
endmodule

bind imseq_sequencer imseq_chk #(.HIGH_SPEED(HIGH_SPEED)) u_imseq_chk (
  .i_ref_clk, .i_reset_n, .i_conversion_toggle, .i_serial_data_clock,
  .i_clock_divide_by_four, .o_data_ready_n, .o_state, .o_continuous,
  .o_measure_busy, .o_inputs_grounded, .o_integrate_a, .o_integrate_b,
  .o_measure_side_b
);

// >>> tb/imseq_host_model.sv
/*
  Host model: drives the conversion toggle and the serial data clock.
  Assumes its tasks are called at a falling edge of the system clock.
*/
`timescale 1ns/1ps
module imseq_host_model (
  input wire logic i_ref_clk,
  input wire logic i_serial_out,
  output logic o_conversion_toggle,
  output logic o_serial_data_clock
);
  // ****************************************
  // Host actions
  // ****************************************
  initial begin
    o_conversion_toggle = 1'b0;
    o_serial_data_clock = 1'b0;
  end
  task automatic flip();
    o_conversion_toggle = !o_conversion_toggle;
  endtask
  // Slow enough for the two-stage sync; clock idles low between words
  task automatic pulse();
    o_serial_data_clock = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    o_serial_data_clock = 1'b0;
    repeat (5) @(negedge i_ref_clk);
  endtask
  task automatic read_word(output logic [19:0] w);
    for (int b = 19; b >= 0; b--) begin
      w[b] = i_serial_out;
      pulse();
    end
  endtask
endmodule

// >>> tb/imseq_sequencer_tb_top.sv
/*
  Self-checking bench of the sequencer with a host model.
  Assumes the low-power build and a 40 ns system clock.
*/
`timescale 1ns/1ps
module imseq_sequencer_tb_top;
  logic clk, reset_n, div4, fmt, tog, sclk, rdy_n, sout;
  logic cont, busy, gnd, int_a, int_b, side_b;
  logic [1:0] phase;
  logic [2:0] state;
  logic [19:0] code_a, code_b, word;
  int err_count, total_checks;

  imseq_sequencer #(.HIGH_SPEED(1'b0)) u_imseq_sequencer (
    .i_ref_clk(clk), .i_reset_n(reset_n), .i_conversion_toggle(tog),
    .i_serial_data_clock(sclk), .i_clock_divide_by_four(div4),
    .i_format_full(fmt), .i_code_a(code_a), .i_code_b(code_b),
    .o_data_ready_n(rdy_n), .o_serial_out(sout), .o_state(state),
    .o_continuous(cont), .o_measure_busy(busy), .o_inputs_grounded(gnd),
    .o_integrate_a(int_a), .o_integrate_b(int_b), .o_measure_side_b(side_b),
    .o_phase(phase)
  );
  imseq_host_model u_host (.i_ref_clk(clk), .i_serial_out(sout),
    .o_conversion_toggle(tog), .o_serial_data_clock(sclk));

  // ****************************************
  // Shared checks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [19:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_state(input logic [2:0] e, input int lim);
    int c;
    c = 0;
    while (state !== e && c < lim) begin
      @(negedge clk);
      c++;
    end
    chk("state", 20'(e), 20'(state));
    if (state !== e) complete_run();
  endtask
  // Counts falling edges from the call until ready goes low
  task automatic wait_ready(input int lo, hi);
    int c;
    c = 0;
    while (rdy_n !== 1'b0 && c <= hi) begin
      @(negedge clk);
      c++;
    end
    total_checks++;
    if (c < lo || c > hi) begin
      err_count++;
      $display("Error ready delay expected %0d to %0d seen %0d", lo, hi, c);
      complete_run();
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_powerup();
    chk("state", 20'h0_0007, 20'(state));
    wait_state(3'd5, 600);
    chk("cont", 20'h0_0001, 20'(cont));
    chk("ground", 20'h0_0000, 20'(gnd));
    chk("int b", 20'h0_0001, 20'(int_b));
    $display("t_powerup done");
  endtask
  task automatic t_cont();
    code_b = 20'h0_0123;
    u_host.flip();
    wait_state(3'd4, 8);
    chk("side", 20'h0_0001, 20'(side_b));
    chk("phase", 20'(imseq_pkg::PH_CONVERT), 20'(phase));
    wait_ready(1380, 1392);
    chk("busy", 20'h0_0001, 20'(busy));
    u_host.read_word(word);
    chk("word b", 20'h0_1123, word);
    chk("ready", 20'h0_0001, 20'(rdy_n));
    chk("busy", 20'h0_0000, 20'(busy));
    fmt = 1'b0;
    code_a = 20'h0_0ABC;
    repeat (100) @(negedge clk);
    u_host.flip();
    wait_state(3'd3, 8);
    chk("side", 20'h0_0000, 20'(side_b));
    wait_ready(1380, 1392);
    u_host.read_word(word);
    chk("word a", 20'h0_1AB0, word);
    $display("t_cont done");
  endtask
  // Second toggle lands mid-measure on purpose
  task automatic t_drop();
    fmt = 1'b1;
    repeat (100) @(negedge clk);
    u_host.flip();
    wait_state(3'd4, 8);
    repeat (100) @(negedge clk);
    u_host.flip();
    wait_state(3'd7, 8);
    chk("ground", 20'h0_0001, 20'(gnd));
    wait_ready(1270, 1292);
    u_host.pulse();
    chk("ready", 20'h0_0001, 20'(rdy_n));
    wait_ready(129, 139);
    u_host.read_word(word);
    chk("word a", 20'h0_1ABC, word);
    wait_state(3'd5, 3000);
    chk("cont", 20'h0_0001, 20'(cont));
    $display("t_drop done");
  endtask
  task automatic t_div4();
    div4 = 1'b1;
    code_b = 20'hF_E000;
    repeat (1600) @(negedge clk);
    u_host.flip();
    wait_state(3'd4, 40);
    wait_ready(5524, 5548);
    u_host.read_word(word);
    chk("clip", 20'h0_0000, word);
    $display("t_div4 done");
  endtask
  // Mid-run reset with the toggle high: the state 1 start-up path
  task automatic t_restart();
    div4 = 1'b0;
    code_a = 20'h0_0040;
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk("state", 20'h0_0007, 20'(state));
    wait_state(3'd2, 600);
    chk("int a", 20'h0_0001, 20'(int_a));
    u_host.flip();
    wait_state(3'd3, 8);
    chk("side", 20'h0_0000, 20'(side_b));
    wait_ready(1380, 1392);
    u_host.read_word(word);
    chk("word a", 20'h0_1040, word);
    $display("t_restart done");
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  initial begin
    err_count = 0;
    total_checks = 0;
    reset_n = 1'b0;
    div4 = 1'b0;
    fmt = 1'b1;
    code_a = 20'h0_0000;
    code_b = 20'h0_0000;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    t_powerup();
    t_cont();
    t_drop();
    t_div4();
    t_restart();
    complete_run();
  end
endmodule
